// >>> design/tvsic_ctrl.sv
// Two-wire control-port slave of a TV sound processor with APB access.
// Assumes scl/sda and the address straps are asynchronous pins and the
// APB master runs on clk_sys.
//
// Operation
// R1: Answer address 10110 plus two strap pins
// R2: Never react to the general call
// R3: Fast-mode slave, master stays under 400k
// R4: Keep serving transfers while in standby
// R5: Control by register writes, status readable
// R6: Power-up: outputs muted, no carrier, GPIO high
// R7: Power-up: first input, AGC on, 0 dB
// R8: Power-up: both demodulators FM, default identification
// R9: Power-up: main channel FM, effects off, mute
// R10: Power-up: auxiliary channel FM, mute, flat
// R11: Power-up: feature outputs off, carrier-1 monitor
// R12: Host reinitialises everything after power-up
// R13: Forty-six subaddressed writable command registers
// R14: Store, increment subaddress, acknowledge each byte
// R15: Subaddress never wraps past the last
// R16: Multi-byte functions commit only when complete
// R17: Stop without acknowledge is a bus error
// R18: Ack own write address and subaddress only; the code also acks its own read address
module tvsic_ctrl
   import tvsic_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst,
   // Two-wire link
   input  wire logic              scl_in,
   input  wire logic              sda_in,
   output logic                   sda_out,
   output logic                   sda_oe,
   // Address straps
   input  wire logic              address_select_high_pin,
   input  wire logic              address_select_low_pin,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [APB_AW-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Committed settings towards the audio core
   output logic                   cfg_wr_valid,
   output logic      [SUB_W-1:0]  cfg_wr_addr,
   output logic      [7:0]        cfg_wr_data,
   output logic                   standby
);

   typedef enum logic [3:0] {
      S_IDLE, S_ADDR, S_ACK_ADDR, S_SUB, S_ACK_SUB, S_DATA, S_ACK_DATA,
      S_READ, S_READ_ACK, S_READ_NEXT, S_IGNORE
   } tvsic_state_t;

   function automatic logic [7:0] grp_base(input logic [7:0] a);
      logic [7:0] b;
      b = a;
      if (a >= FREQ1_FIRST && a <= FREQ1_LAST)
         b = FREQ1_FIRST;
      if (a >= FREQ2_FIRST && a <= FREQ2_LAST)
         b = FREQ2_FIRST;
      return b;
   endfunction : grp_base

   function automatic logic in_group(input logic [7:0] a);
      return a >= FREQ1_FIRST && a <= FREQ2_LAST;
   endfunction : in_group

   // Synchronised pins
   logic [3:0]   pins_s;
   logic         scl_d;
   logic         sda_d;
   tvsic_state_t state;
   logic [3:0]   cnt;
   logic [7:0]   shreg;
   logic [7:0]   ptr;
   logic         rw;
   logic         rd_idx;
   logic [7:0]   tx;
   logic [7:0]   stg [GRP_LEN];
   logic [2:0]   stg_mask;
   logic [1:0]   cm_cnt;
   logic [7:0]   cm_base;
   logic         bus_err;
   logic         pwr_flag;
   logic         init_pulse;
   logic [7:0]   devstat;
   logic [7:0]   mem_rdata;

   tvsic_sync #(
      .WIDTH     (4),
      .RESET_VAL (PINS_IDLE)
   ) u_sync (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .async_in ({scl_in, sda_in, address_select_high_pin,
                  address_select_low_pin}),
      .sync_out (pins_s)
   );

   wire       scl_s      = pins_s[3];
   wire       sda_s      = pins_s[2];
   wire [6:0] own_addr   = {ADDR_PREFIX, pins_s[1], pins_s[0]}; // see R1
   wire       scl_rise   = scl_s & ~scl_d;
   wire       scl_fall   = ~scl_s & scl_d;
   wire       start_cond = scl_s & scl_d & sda_d & ~sda_s;
   wire       stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
   // General call never equals own_addr, whose prefix is non-zero
   wire       addr_match = shreg[7:1] == own_addr; // see R1 R2
   wire       in_rx      = state == S_ADDR || state == S_SUB ||
                           state == S_DATA;
   wire       byte_full  = cnt == 4'h8;
   wire       ptr_ok     = ptr <= LAST_SUB; // see R15
   wire       accept     = scl_fall && state == S_ACK_DATA;
   wire       acc_grp    = in_group(ptr);
   wire [7:0] acc_base   = grp_base(ptr);
   wire [1:0] acc_slot   = 2'(ptr - acc_base);
   wire [2:0] mask_next  = stg_mask | (3'h1 << acc_slot);
   wire       grp_done   = acc_grp && acc_slot == 2'(GRP_LEN - 1) &&
                           mask_next == GRP_FULL;
   // The stop's clock rise counts one; more means a torn byte
   wire       err_set    = stop_cond && in_rx && cnt > 4'h1;

   // Memory write selection: group commit or a single direct byte
   wire             cm_active = cm_cnt != 2'h0;
   wire [1:0]       cm_slot   = 2'(GRP_LEN - int'(cm_cnt));
   wire             direct_we = accept && !acc_grp;
   wire             mem_we    = (cm_active | direct_we) & ~init_pulse;
   wire [SUB_W-1:0] mem_waddr = cm_active ?
                                SUB_W'(cm_base + 8'(cm_slot)) :
                                SUB_W'(ptr);
   wire [7:0]       mem_wdata = cm_active ? stg[cm_slot] : shreg;

   // APB decode
   wire [7:0]  apb_idx    = paddr[9:2];
   wire        apb_hi_ok  = paddr[APB_AW-1:10] == '0;
   wire        is_cmd     = apb_hi_ok && int'(apb_idx) < NUM_REGS;
   wire        is_ctrl    = apb_hi_ok && apb_idx == IDX_CTRL;
   wire        is_stat    = apb_hi_ok && apb_idx == IDX_STATUS;
   wire        is_dev     = apb_hi_ok && apb_idx == IDX_DEVSTAT;
   wire        rd_ok      = is_cmd | is_ctrl | is_stat | is_dev;
   wire        wr_ok      = is_ctrl | is_stat | is_dev;
   wire        apb_access = psel & penable & ~pready;
   wire        apb_bad    = pwrite ? ~wr_ok : ~rd_ok;
   wire        apb_wr     = psel & penable & pready & pwrite & ~pslverr;
   wire [ST_W-1:0] status_bits;
   assign status_bits = {standby, state != S_IDLE, pwr_flag, bus_err};
   wire [7:0]  tx_byte    = rd_idx ? {4'h0, status_bits} : devstat;
   wire [31:0] rd_mux     = is_cmd  ? {24'h0, mem_rdata} :
                            is_ctrl ? {30'h0, standby, 1'b0} :
                            is_stat ? {28'h0, status_bits} :
                            is_dev  ? {24'h0, devstat} : 32'h0;
   wire        clr_err    = apb_wr && is_stat && pwdata[ST_BUSERR];
   wire        clr_pwr    = apb_wr && is_stat && pwdata[ST_PWRUP];

   tvsic_regmem u_mem (
      .clk_sys (clk_sys),
      .rst     (rst),
      .init    (init_pulse),
      .we      (mem_we),         // see R13
      .waddr   (mem_waddr),
      .wdata   (mem_wdata),
      .raddr   (SUB_W'(apb_idx)),
      .rdata   (mem_rdata)
   );

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   // Link state machine; no standby gating
   always_ff @(posedge clk_sys) begin // see R3 R4
      if (rst) begin
         state   <= S_IDLE;
         cnt     <= 4'h0;
         shreg   <= 8'h00;
         ptr     <= 8'h00;
         rw      <= 1'b0;
         rd_idx  <= 1'b0;
         tx      <= 8'h00;
         sda_oe  <= 1'b0;
      end else if (start_cond) begin
         state  <= S_ADDR;
         cnt    <= 4'h0;
         sda_oe <= 1'b0;
      end else if (stop_cond) begin
         state  <= S_IDLE;
         sda_oe <= 1'b0;
      end else if (scl_rise) begin
         if (in_rx) begin
            shreg <= {shreg[6:0], sda_s};
            cnt   <= cnt + 4'h1;
         end else if (state == S_READ) begin
            cnt <= cnt + 4'h1;
         end else if (state == S_READ_ACK) begin
            // Master high on the ack bit ends the read
            state  <= sda_s ? S_IGNORE : S_READ_NEXT;
            rd_idx <= sda_s ? rd_idx : 1'b1;
         end
      end else if (scl_fall) begin
         unique case (state)
            S_ADDR: begin
               if (byte_full) begin
                  state  <= addr_match ? S_ACK_ADDR : S_IGNORE; // see R18
                  sda_oe <= addr_match;
                  rw     <= shreg[0];
               end
            end
            S_ACK_ADDR: begin
               cnt <= 4'h0;
               if (rw) begin
                  // Readable status for the host
                  state  <= S_READ; // see R5
                  rd_idx <= 1'b0;
                  tx     <= devstat;
                  sda_oe <= ~devstat[7];
               end else begin
                  state  <= S_SUB;
                  sda_oe <= 1'b0;
               end
            end
            S_SUB: begin
               if (byte_full) begin
                  ptr    <= shreg;
                  state  <= shreg <= LAST_SUB ? S_ACK_SUB : S_IGNORE;
                  sda_oe <= shreg <= LAST_SUB; // see R18
               end
            end
            S_ACK_SUB: begin
               state  <= S_DATA;
               cnt    <= 4'h0;
               sda_oe <= 1'b0;
            end
            S_DATA: begin
               if (byte_full) begin
                  // Past the last register: refuse, do not wrap
                  state  <= ptr_ok ? S_ACK_DATA : S_IGNORE; // see R15
                  sda_oe <= ptr_ok; // see R14
               end
            end
            S_ACK_DATA: begin
               state  <= S_DATA;
               cnt    <= 4'h0;
               sda_oe <= 1'b0;
               ptr    <= ptr + 8'h1; // see R14
            end
            S_READ: begin
               if (cnt < 4'h8)
                  sda_oe <= ~tx[3'(4'h7 - cnt)];
               else begin
                  sda_oe <= 1'b0;
                  state  <= S_READ_ACK;
               end
            end
            S_READ_NEXT: begin
               tx     <= tx_byte;
               sda_oe <= ~tx_byte[7];
               cnt    <= 4'h0;
               state  <= S_READ;
            end
            S_IDLE, S_READ_ACK, S_IGNORE: begin
               sda_oe <= 1'b0;
            end
         endcase
      end
   end

   // Staging for multi-byte functions; a stop or start drops a partial
   always_ff @(posedge clk_sys) begin
      if (rst || init_pulse || start_cond || stop_cond) begin
         stg_mask <= 3'h0; // see R16
      end else if (accept && acc_grp) begin
         stg[acc_slot] <= shreg;
         stg_mask      <= grp_done ? 3'h0 : mask_next;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst || init_pulse) begin
         cm_cnt  <= 2'h0;
         cm_base <= 8'h00;
      end else if (accept && grp_done) begin
         cm_cnt  <= 2'(GRP_LEN); // see R16
         cm_base <= acc_base;
      end else if (cm_active) begin
         cm_cnt <= cm_cnt - 2'h1;
      end
   end

   // Stored byte announced to the audio core
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cfg_wr_valid <= 1'b0;
         cfg_wr_addr  <= '0;
         cfg_wr_data  <= 8'h00;
         sda_out      <= 1'b0;
      end else begin
         cfg_wr_valid <= mem_we;
         cfg_wr_addr  <= mem_waddr;
         cfg_wr_data  <= mem_wdata;
         sda_out      <= 1'b0;
      end
   end

   // Sticky flags: a set in the clear cycle wins
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         bus_err  <= 1'b0;
         pwr_flag <= 1'b1;
      end else begin
         bus_err  <= (bus_err & ~clr_err) | err_set; // see R17
         pwr_flag <= (pwr_flag & ~clr_pwr) | init_pulse;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= apb_access;
         pslverr <= apb_access & apb_bad;
         prdata  <= (apb_access && !pwrite) ? rd_mux : 32'h0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         standby    <= 1'b0;
         init_pulse <= 1'b0;
         devstat    <= 8'h00;
      end else begin
         init_pulse <= apb_wr && is_ctrl && pwdata[CTRL_INIT];
         if (apb_wr && is_ctrl)
            standby <= pwdata[CTRL_STBY];
         if (apb_wr && is_dev)
            devstat <= pwdata[7:0];
      end
   end

endmodule : tvsic_ctrl

// >>> design/tvsic_pkg.sv
// Constants shared by the TV sound control-port slave and its helpers.
// Assumes a 200 MHz system clock; the two-wire link is oversampled.
package tvsic_pkg;

   // Command register file
   localparam int          NUM_REGS    = 46;
   localparam int          SUB_W       = 6;
   localparam logic [7:0]  LAST_SUB    = 8'h2D;
   localparam logic [4:0]  ADDR_PREFIX = 5'h16;

   // Multi-byte functions: carrier frequencies, three bytes each
   localparam int          GRP_LEN     = 3;
   localparam logic [7:0]  FREQ1_FIRST = 8'h03;
   localparam logic [7:0]  FREQ1_LAST  = 8'h05;
   localparam logic [7:0]  FREQ2_FIRST = 8'h06;
   localparam logic [7:0]  FREQ2_LAST  = 8'h08;
   localparam logic [2:0]  GRP_FULL    = 3'h7;

   // Subaddresses with their own power-up value; only SUB_MUTE is non-zero
   localparam logic [7:0]  SUB_MUTE    = 8'h12;
   localparam logic [7:0]  SUB_VOL_ML  = 8'h1A;
   localparam logic [7:0]  SUB_VOL_MR  = 8'h1B;
   localparam logic [7:0]  SUB_VOL_AL  = 8'h20;
   localparam logic [7:0]  SUB_VOL_AR  = 8'h21;

   // Power-up values; zero codes select FIRST_CARRIER_INPUT, AGC on, FM, flat tone
   localparam logic [7:0]  DEF_ZERO    = 8'h00;
   localparam logic [7:0]  DEF_MUTE    = 8'hFF;
   localparam logic [7:0]  DEF_VOL_OFF = 8'h00;

   // APB map, word index = byte address / 4
   localparam int          APB_AW      = 12;
   localparam logic [7:0]  IDX_CTRL    = 8'h30;
   localparam logic [7:0]  IDX_STATUS  = 8'h31;
   localparam logic [7:0]  IDX_DEVSTAT = 8'h32;
   localparam int          CTRL_INIT   = 0;
   localparam int          CTRL_STBY   = 1;
   localparam int          ST_BUSERR   = 0;
   localparam int          ST_PWRUP    = 1;
   localparam int          ST_BUSY     = 2;
   localparam int          ST_STBY     = 3;
   localparam int          ST_W        = 4;

   // Link speed ceiling, kbit/s, and the oversampling it implies
   localparam int          LINK_KBPS   = 400;
   localparam int          CLK_KHZ     = 200000;
   localparam int          CYC_PER_BIT = CLK_KHZ / LINK_KBPS;

   localparam logic [3:0]  PINS_IDLE   = 4'hF;

   function automatic logic [7:0] reg_default(input logic [7:0] sub);
      logic [7:0] val;
      val = DEF_ZERO;
      if (sub == SUB_MUTE)
         val = DEF_MUTE;
      if (sub == SUB_VOL_ML || sub == SUB_VOL_MR ||
          sub == SUB_VOL_AL || sub == SUB_VOL_AR)
         val = DEF_VOL_OFF;
      return val;
   endfunction : reg_default

endpackage : tvsic_pkg

// >>> design/tvsic_sync.sv
// Two-flop synchroniser for a vector of unrelated pin levels.
// Assumes each bit may change at any time relative to clk_sys.
module tvsic_sync
   import tvsic_pkg::*;
#(
   parameter int               WIDTH     = 4,
   parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst,
   // Levels
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta;

   // First stage feeds only the second
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         meta     <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule : tvsic_sync

// >>> design/tvsic_regmem.sv
// Command register store with power-up values and a registered read.
// Assumes one writer per cycle; init has priority over a write.
module tvsic_regmem
   import tvsic_pkg::*;
(
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             init,
   // Write port
   input  wire logic             we,
   input  wire logic [SUB_W-1:0] waddr,
   input  wire logic [7:0]       wdata,
   // Read port
   input  wire logic [SUB_W-1:0] raddr,
   output logic      [7:0]       rdata
);

   logic [7:0] store [NUM_REGS];

   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < NUM_REGS; i++) begin
         if (rst || init)
            store[i] <= reg_default(8'(i)); // see R6 R7 R8 R9 R10 R11
         else if (we && int'(waddr) == i)
            store[i] <= wdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst)
         rdata <= DEF_ZERO;
      else if (int'(raddr) < NUM_REGS)
         rdata <= store[raddr];
      else
         rdata <= DEF_ZERO;
   end

endmodule : tvsic_regmem

// >>> test/tvsic_ctrl_sva.sv
// Checker for the control-port slave: APB timing, link drive, commits.
// Sees only the top ports; bound to every tvsic_ctrl below.
module tvsic_ctrl_sva
   import tvsic_pkg::*;
(
   // Clock and reset
   input wire logic              clk_sys,
   input wire logic              rst,
   // Link
   input wire logic              scl_in,
   input wire logic              sda_out,
   input wire logic              sda_oe,
   // APB
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // Commit side
   input wire logic              cfg_wr_valid,
   input wire logic [SUB_W-1:0]  cfg_wr_addr,
   input wire logic              standby
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire acc = psel && penable && !pready;
   wire cmd = paddr[11:10] == 2'h0 && paddr[9:2] <= LAST_SUB;

   a_apb_answer: assert property (
      psel && !penable ##1 acc |=> pready) else $error("pready late");
   a_pready_pulse: assert property (
      pready |=> !pready) else $error("pready held");
   a_cmd_wr_refused: assert property (
      acc && pwrite && cmd |=> pready && pslverr)
      else $error("command write accepted");
   a_cmd_rd_ok: assert property (
      acc && !pwrite && cmd |=> !pslverr && prdata[31:8] == 24'h0)
      else $error("command read bad");
   a_standby_set: assert property (
      pready && pwrite && paddr == 12'h0C0 |=> standby == $past(pwdata[1]))
      else $error("standby not updated");
   a_drain_only: assert property (
      sda_oe |-> !sda_out) else $error("data line driven high");
   a_oe_scl_low: assert property (
      $changed(sda_oe) |-> !scl_in) else $error("data moved in clock high");
   a_sub_range: assert property (
      cfg_wr_valid |-> cfg_wr_addr <= 6'h2D) else $error("store past end");
   a_step_incr: assert property (
      cfg_wr_valid ##1 cfg_wr_valid |-> cfg_wr_addr == $past(cfg_wr_addr) + 6'h1)
      else $error("group order");
   a_group_whole: assert property (
      cfg_wr_valid && cfg_wr_addr == 6'h03 |=> cfg_wr_valid ##1
      cfg_wr_valid && cfg_wr_addr == 6'h05) else $error("group split");

   c_refused: cover property (pready && pslverr);
   c_group: cover property (cfg_wr_valid && cfg_wr_addr == 6'h03);
   c_standby: cover property ($rose(standby));
endmodule : tvsic_ctrl_sva

bind tvsic_ctrl tvsic_ctrl_sva u_sva (.clk_sys(clk_sys), .rst(rst),
   .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .cfg_wr_valid(cfg_wr_valid), .cfg_wr_addr(cfg_wr_addr),
   .standby(standby));

// >>> test/tvsic_host.sv
// Two-wire bus master standing in for the host controller.
// Assumes a pull-up on the data line: released reads high.
module tvsic_host (
   // Clock
   input  wire logic clk_sys,
   // Bus
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_low
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : wait_clk

   // Clock stands high between frames
   task automatic start_cond();
      sda_low <= 1'b1;
      wait_clk(16);
      scl <= 1'b0;
   endtask : start_cond

   // 160 ns slot; data moves mid-low, off both edges
   task automatic bit_slot(input logic v, output logic r);
      wait_clk(8);
      sda_low <= !v;
      wait_clk(8);
      scl <= 1'b1;
      wait_clk(16);
      r = sda_line;
      scl <= 1'b0;
   endtask : bit_slot

   task automatic stop_cond();
      wait_clk(8);
      sda_low <= 1'b1;
      wait_clk(8);
      scl <= 1'b1;
      wait_clk(16);
      sda_low <= 1'b0;
      wait_clk(16);
   endtask : stop_cond

   // Top n bits, MSB first; ack slot only after 8
   task automatic send(input logic [7:0] b, input int n, output logic ack);
      logic r;
      ack = 1'b0;
      for (int i = 7; i > 7 - n; i--)
         bit_slot(b[i], r);
      if (n == 8) begin
         bit_slot(1'b1, r);
         ack = !r;
      end
   endtask : send

   task automatic recv(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(1'b1, r);
         b[i] = r;
      end
      bit_slot(last, r);
   endtask : recv
endmodule : tvsic_host

// >>> test/tb.sv
// Bench for the control-port slave: APB tasks, byte monitor.
// Assumes tvsic_host as link master.
module tb
   import tvsic_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] ADDR_W = {ADDR_PREFIX, 2'h3};
   logic              clk_sys, rst, psel, penable, pwrite, pready;
   logic [APB_AW-1:0] paddr;
   logic [31:0]       pwdata, prdata;
   logic              pslverr, sda_out, sda_oe, standby, sel_hi, sel_lo;
   logic              cfg_wr_valid;
   logic [SUB_W-1:0]  cfg_wr_addr;
   logic [7:0]        cfg_wr_data;
   wire               scl, sda_low;
   wire               sda_line = !(sda_low || (sda_oe && !sda_out));
   int                n_fail, checked;
   logic [13:0]       cfgq[$];

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = !clk_sys;
   end

   tvsic_ctrl DUT (.clk_sys(clk_sys), .rst(rst), .scl_in(scl),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
      .address_select_high_pin(sel_hi), .address_select_low_pin(sel_lo),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cfg_wr_valid(cfg_wr_valid),
      .cfg_wr_addr(cfg_wr_addr), .cfg_wr_data(cfg_wr_data),
      .standby(standby));
   tvsic_host host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl),
      .sda_low(sda_low));

   always @(posedge clk_sys)
      if (cfg_wr_valid === 1'b1)
         cfgq.push_back({cfg_wr_addr, cfg_wr_data});

   task automatic cmp(input logic [31:0] got, exp, input string m);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : cmp

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up

   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic e);
      int k;
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         n_fail++;
         $display("[FAIL] %0t apb hang", $time);
         wrap_up();
      end
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Data d0, d0+1, ...; acks counts acked bytes
   task automatic link_wr(input logic [6:0] a, input logic [7:0] sub,
         input int n, input logic [7:0] d0, output int acks);
      logic ack;
      host.start_cond();
      host.send({a, 1'b0}, 8, ack);
      acks = int'(ack);
      host.send(sub, 8, ack);
      acks += int'(ack);
      for (int i = 0; i < n; i++) begin
         host.send(d0 + 8'(i), 8, ack);
         acks += int'(ack);
      end
      host.stop_cond();
   endtask : link_wr

   task automatic t_defaults();
      logic [31:0] q;
      logic        e;
      for (int i = 0; i < NUM_REGS; i++) begin
         apb(1'b0, 12'(4 * i), 32'h0, q, e);
         cmp(q, (i == 18) ? 32'hFF : 32'h0, "power-up value");
         cmp(e, 1'b0, "command read refused");
      end
      apb(1'b0, 12'h0C4, 32'h0, q, e);
      cmp(q[1], 1'b1, "power flag");
      apb(1'b1, 12'h048, 32'h0, q, e);
      cmp(e, 1'b1, "command write taken");
      apb(1'b0, 12'h0FC, 32'h0, q, e);
      cmp(e, 1'b1, "unmapped read taken");
      $display("t_defaults done");
   endtask : t_defaults

   task automatic t_addr();
      int acks;
      cfgq.delete();
      for (int s = 0; s < 4; s++) begin
         sel_hi <= s[1];
         sel_lo <= s[0];
         repeat (4) @(posedge clk_sys);
         for (int t = 0; t < 4; t++) begin
            link_wr({ADDR_PREFIX, 2'(t)}, SUB_MUTE, 1, 8'(64 + 4 * s + t),
               acks);
            cmp(acks, (t == s) ? 3 : 0, "address ack");
         end
      end
      link_wr(7'h00, SUB_MUTE, 1, 8'h99, acks);
      cmp(acks, 0, "general call acked");
      cmp(cfgq.size(), 4, "store count");
      for (int s = 0; s < 4; s++)
         cmp(cfgq[s], {6'h12, 8'(64 + 5 * s)}, "stored byte");
      $display("t_addr done");
   endtask : t_addr

   task automatic t_autoinc();
      int          acks;
      logic [31:0] q;
      logic        e;
      cfgq.delete();
      link_wr(ADDR_W, 8'h2B, 4, 8'hC0, acks);
      cmp(acks, 5, "ack count at top");
      cmp(cfgq.size(), 3, "store count at top");
      for (int i = 0; i < 3; i++)
         cmp(cfgq[i], {6'(43 + i), 8'(192 + i)}, "auto-increment");
      link_wr(ADDR_W, 8'h2E, 1, 8'h11, acks);
      cmp(acks, 1, "subaddress past end");
      apb(1'b0, 12'h0B4, 32'h0, q, e);
      cmp(q, 32'hC2, "stored value");
      $display("t_autoinc done");
   endtask : t_autoinc

   task automatic t_group();
      int          acks;
      logic        ack;
      logic [31:0] q;
      logic        e;
      cfgq.delete();
      link_wr(ADDR_W, FREQ1_FIRST, 3, 8'h10, acks);
      cmp(cfgq.size(), 3, "whole group");
      cmp(cfgq[2], {6'h05, 8'h12}, "group tail");
      link_wr(ADDR_W, FREQ2_FIRST, 2, 8'h20, acks);
      cmp(acks, 4, "partial group ack");
      cmp(cfgq.size(), 3, "partial group stored");
      apb(1'b0, 12'h0C4, 32'h0, q, e);
      cmp(q[0], 1'b0, "stop error");
      // Torn byte: four bits
      host.start_cond();
      host.send({ADDR_W, 1'b0}, 8, ack);
      host.send(8'h09, 8, ack);
      host.send(8'hF0, 4, ack);
      host.stop_cond();
      cmp(cfgq.size(), 3, "torn byte stored");
      apb(1'b0, 12'h0C4, 32'h0, q, e);
      cmp(q[0], 1'b1, "bus error flag");
      apb(1'b1, 12'h0C4, 32'h1, q, e);
      apb(1'b0, 12'h0C4, 32'h0, q, e);
      cmp(q[0], 1'b0, "bus error clear");
      $display("t_group done");
   endtask : t_group

   task automatic t_standby();
      int          acks;
      logic        ack;
      logic [7:0]  b;
      logic [31:0] q;
      logic        e;
      apb(1'b1, 12'h0C0, 32'h2, q, e);
      @(posedge clk_sys);
      cmp(standby, 1'b1, "standby pin");
      apb(1'b0, 12'h0C4, 32'h0, q, e);
      cmp(q[3], 1'b1, "standby status");
      cfgq.delete();
      link_wr(ADDR_W, 8'h14, 1, 8'h33, acks);
      cmp(cfgq.size(), 1, "store in standby");
      apb(1'b1, 12'h0C8, 32'hA5, q, e);
      host.start_cond();
      host.send({ADDR_W, 1'b1}, 8, ack);
      host.recv(1'b1, b);
      host.stop_cond();
      cmp(b, 8'hA5, "status byte");
      apb(1'b1, 12'h0C4, 32'h2, q, e);
      apb(1'b1, 12'h0C0, 32'h1, q, e);
      apb(1'b0, 12'h048, 32'h0, q, e);
      cmp(q, 32'hFF, "mute after init");
      apb(1'b0, 12'h0C4, 32'h0, q, e);
      cmp(q[1], 1'b1, "init flag");
      $display("t_standby done");
   endtask : t_standby

   initial begin
      rst     = 1'b1;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = '0;
      pwdata  = 32'h0;
      sel_hi  = 1'b0;
      sel_lo  = 1'b0;
      n_fail  = 0;
      checked = 0;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (8) @(posedge clk_sys);
      t_defaults();
      t_addr();
      t_autoinc();
      t_group();
      t_standby();
      wrap_up();
   end
endmodule : tb
